/* File: src/trs_pkg.sv */
// Constants, state codes and register map of the triple rail sequencer.
// Assumes a 200 MHz mclk; all long intervals are counted in timebase ticks.
package trs_pkg;
    // Timebase
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_NS = 10000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam int IVL_W = 10;
    localparam int PWRUP_DIS_US = 5000;
    localparam int GAP_US = 1000;
    localparam int SSDIS_US = 500;
    localparam int HICCUP_US = 7000;
    localparam logic [IVL_W-1:0] PWRUP_TICKS = IVL_W'(PWRUP_DIS_US * 1000 / TICK_NS);
    localparam logic [IVL_W-1:0] GAP_TICKS = IVL_W'(GAP_US * 1000 / TICK_NS);
    localparam logic [IVL_W-1:0] SSDIS_TICKS = IVL_W'(SSDIS_US * 1000 / TICK_NS);
    localparam logic [IVL_W-1:0] HICCUP_TICKS = IVL_W'(HICCUP_US * 1000 / TICK_NS);
    localparam logic [IVL_W-1:0] IVL_ZERO = 10'h000;
    // Overcurrent suppression lengths
    localparam int LEN_W = 5;
    localparam logic [LEN_W-1:0] OC_LEN_MIN = 5'h01;
    localparam logic [LEN_W-1:0] OC_LEN_MAX = 5'h10;
    localparam logic [LEN_W-1:0] OC_CNT_ZERO = 5'h00;
    // Input synchroniser width
    localparam int SYNC_W = 18;
    // APB register map
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
    localparam int IRQ_W = 6;
    localparam int IRQ_TSD = 0;
    localparam int IRQ_UNDERVOLTAGE_LOCKOUT = 1;
    localparam int IRQ_WARN = 2;
    localparam int IRQ_HIC0 = 3;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [IRQ_W-1:0] MASK_RST = 6'h00;
    // Sequencer states
    typedef enum logic [2:0] {
        S_DISCH = 3'b000,
        S_LOCK = 3'b001,
        S_IDLE = 3'b010,
        S_SSDIS = 3'b011,
        S_PRE = 3'b100,
        S_RAMP = 3'b101,
        S_GAP = 3'b110
    } trs_state_t;
endpackage

/* File: src/trs_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes inputs come from comparators outside the mclk domain.
`timescale 1ns/10ps
module trs_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1Q;
    logic [W-1:0] s2Q;
    logic [W-1:0] s3Q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1Q <= '0;
            s2Q <= '0;
            s3Q <= '0;
            dout <= '0;
        end else begin
            s1Q <= din;
            s2Q <= s1Q;
            s3Q <= s2Q;
            // A bit changes only once stages two and three agree
            dout <= (s3Q & ~(s2Q ^ s3Q)) | (dout & (s2Q ^ s3Q));
        end
    end
endmodule

/* File: src/trs_ocp.sv */
// Per-rail cycle-by-cycle overcurrent suppression with doubling length.
// Assumes swTick is a one-cycle pulse per switching cycle, ocDet a synchronised level.
`timescale 1ns/10ps
module trs_ocp import trs_pkg::*; (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Rail state
    input wire logic active,
    input wire logic swTick,
    input wire logic ocDet,
    // Results
    output logic blank,
    output logic streak
);
    logic [LEN_W-1:0] lenQ;
    logic [LEN_W-1:0] cntQ;
    logic check;

    // Sampled only in cycles that actually switched
    assign check = swTick && (cntQ == OC_CNT_ZERO);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lenQ <= OC_LEN_MIN;
            cntQ <= OC_CNT_ZERO;
        end else if (!active) begin
            lenQ <= OC_LEN_MIN;
            cntQ <= OC_CNT_ZERO;
        end else if (check) begin
            if (ocDet) begin
                cntQ <= lenQ;
                lenQ <= (lenQ == OC_LEN_MAX) ? OC_LEN_MAX : LEN_W'(lenQ << 1);
            end else begin
                lenQ <= OC_LEN_MIN;
            end
        end else if (swTick) begin
            cntQ <= cntQ - OC_LEN_MIN;
        end
    end

    assign blank = (cntQ != OC_CNT_ZERO);
    assign streak = (lenQ != OC_LEN_MIN);

    AST_OC_BLANK: assert property (@(posedge mclk) disable iff (!arst_n)
        active && check && ocDet |=> blank && (cntQ == $past(lenQ)))
        else $error("overcurrent did not suppress the next cycle");
    AST_OC_DOUBLE: assert property (@(posedge mclk) disable iff (!arst_n)
        active && check && ocDet && (lenQ != OC_LEN_MAX) |=> lenQ == LEN_W'($past(lenQ) << 1))
        else $error("suppression length did not double");
    AST_OC_RESET: assert property (@(posedge mclk) disable iff (!arst_n)
        active && check && !ocDet |=> lenQ == OC_LEN_MIN)
        else $error("suppression length not reset after clean cycle");
endmodule

/* File: src/trs_top.sv */
// Triple rail start-up sequencer with soft-start, overcurrent hiccup and shutdowns.
// Assumes analogue comparators drive the pin inputs and an APB master on mclk.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module trs_top import trs_pkg::*; #(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Rail enable inputs
    input wire logic [2:0] enPinAbove,
    output logic enDischarge,
    // Soft-start node
    input wire logic ssPrechargeOk,
    input wire logic ssRampEnd,
    output logic ssDischarge,
    output logic ssPrecharge,
    output logic ssCharge,
    // Power stages
    input wire logic [2:0] swCycle,
    input wire logic [2:0] overCurrent,
    input wire logic [2:0] underVolt,
    output logic [2:0] railEnable,
    output logic [2:0] hsBlank,
    // Supervisors
    input wire logic supplyLow,
    input wire logic tempTrip,
    input wire logic tempCool,
    input wire logic tempWarn,
    // Interrupt
    output logic irq
);
    logic [SYNC_W-1:0] syncOut;
    logic [2:0] enS, swS, swPrevQ, swTick, ocS, uvS;
    logic ssPreS, ssEndS, uvloS, tripS, coolS, warnS, tick, ivlDone;
    logic [31:0] tickCntQ, rdData;
    trs_state_t stateQ;
    logic [IVL_W-1:0] ivlQ;
    logic [1:0] selQ;
    logic [2:0] selHot, railOnQ, enReq, pending, streak, shut, hicBusy, ctrlQ;
    logic tsdQ, fault, uvloPrevQ, warnPrevQ, tsdPrevQ, mapped, accWr, accRd;
    logic [IRQ_W-1:0] irqStatQ, irqMaskQ, irqEv;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    trs_sync #(.W(SYNC_W)) uSync (
        .mclk(mclk),
        .arst_n(arst_n),
        .din({tempWarn, tempCool, tempTrip, supplyLow, underVolt, overCurrent,
              swCycle, ssRampEnd, ssPrechargeOk, enPinAbove}),
        .dout(syncOut)
    );
    assign {warnS, coolS, tripS, uvloS, uvS, ocS, swS, ssEndS, ssPreS, enS} = syncOut;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            swPrevQ <= 3'h0;
        end else begin
            swPrevQ <= swS;
        end
    end
    assign swTick = swS & ~swPrevQ;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tickCntQ <= 32'h0;
        end else if (tickCntQ >= TICK_CYCLES - 1) begin
            tickCntQ <= 32'h0;
        end else begin
            tickCntQ <= tickCntQ + 32'h1;
        end
    end
    assign tick = (tickCntQ >= TICK_CYCLES - 1);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tsdQ <= 1'b0;
        end else if (tripS) begin
            tsdQ <= 1'b1;
        end else if (coolS) begin
            tsdQ <= 1'b0;
        end
    end
    // lockout follows the supply, not latched
    assign fault = tsdQ | uvloS;

    // request only while the enable input is high
    assign enReq = enS & ~ctrlQ & ~hicBusy;
    assign pending = enReq & ~railOnQ;
    assign ivlDone = (ivlQ == IVL_ZERO);
    assign selHot = 3'h1 << selQ;

    // Sequencer and interval counter
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            stateQ <= S_DISCH;
            ivlQ <= PWRUP_TICKS;
            selQ <= 2'h0;
        end else if (fault) begin
            stateQ <= S_LOCK;
            ivlQ <= IVL_ZERO;
        end else begin
            if (tick && !ivlDone) begin
                ivlQ <= ivlQ - 10'h001;
            end
            case (stateQ)
                S_LOCK: begin
                    stateQ <= S_DISCH;
                    ivlQ <= PWRUP_TICKS;
                end
                S_DISCH: begin
                    if (ivlDone) begin
                        stateQ <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    if (pending != 3'h0) begin
                        selQ <= pending[0] ? 2'h0 : (pending[1] ? 2'h1 : 2'h2);
                        stateQ <= S_SSDIS;
                        ivlQ <= SSDIS_TICKS;
                    end
                end
                S_SSDIS: begin
                    if ((pending & selHot) == 3'h0) begin
                        stateQ <= S_IDLE;
                    end else if (ivlDone) begin
                        stateQ <= S_PRE;
                    end
                end
                S_PRE: begin
                    if ((railOnQ & selHot) == 3'h0) begin
                        stateQ <= S_IDLE;
                    end else if (ssPreS) begin
                        stateQ <= S_RAMP;
                    end
                end
                S_RAMP: begin
                    if ((railOnQ & selHot) == 3'h0) begin
                        stateQ <= S_IDLE;
                    end else if (ssEndS) begin
                        stateQ <= S_GAP;
                        ivlQ <= GAP_TICKS;
                    end
                end
                S_GAP: begin
                    if (ivlDone) begin
                        stateQ <= S_IDLE;
                    end
                end
                default: begin
                    stateQ <= S_LOCK;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            railOnQ <= 3'h0;
        end else if (fault) begin
            railOnQ <= 3'h0;
        end else if (stateQ == S_SSDIS && ivlDone && (pending & selHot) != 3'h0) begin
            railOnQ <= (railOnQ & enReq & ~shut) | selHot;
        end else begin
            railOnQ <= railOnQ & enReq & ~shut;
        end
    end
    assign railEnable = railOnQ;

    // Overcurrent suppression and hiccup per rail
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : gRail
            logic [IVL_W-1:0] hicQ;

            trs_ocp uOcp (
                .mclk(mclk),
                .arst_n(arst_n),
                .active(railOnQ[gi]),
                .swTick(swTick[gi]),
                .ocDet(ocS[gi]),
                .blank(hsBlank[gi]),
                .streak(streak[gi])
            );

            assign shut[gi] = railOnQ[gi] & streak[gi] & uvS[gi];

            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    hicQ <= IVL_ZERO;
                end else if (shut[gi]) begin
                    hicQ <= HICCUP_TICKS;
                end else if (tick && hicQ != IVL_ZERO) begin
                    hicQ <= hicQ - 10'h001;
                end
            end
            assign hicBusy[gi] = (hicQ != IVL_ZERO);

            AST_HICCUP: assert property (@(posedge mclk) disable iff (!arst_n)
                shut[gi] && !fault |=> !railOnQ[gi] && hicQ == HICCUP_TICKS)
                else $error("hiccup shutdown did not take the rail off");
        end
    endgenerate

    assign enDischarge = (stateQ == S_LOCK) || (stateQ == S_DISCH) || fault;
    assign ssDischarge = (stateQ == S_SSDIS);
    assign ssPrecharge = (stateQ == S_PRE);
    // charge current runs through the ramp
    assign ssCharge = (stateQ == S_RAMP);

    // Event edges
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            uvloPrevQ <= 1'b0;
            warnPrevQ <= 1'b0;
            tsdPrevQ <= 1'b0;
        end else begin
            uvloPrevQ <= uvloS;
            warnPrevQ <= warnS;
            tsdPrevQ <= tsdQ;
        end
    end
    assign irqEv = {shut, warnS & ~warnPrevQ, uvloS & ~uvloPrevQ, tsdQ & ~tsdPrevQ};

    // APB: zero wait states, error on unmapped offsets
    assign mapped = hit(paddr, CTRL_OFS) || hit(paddr, STATUS_OFS) ||
                    hit(paddr, IRQ_STAT_OFS) || hit(paddr, IRQ_MASK_OFS);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign accWr = psel && penable && pwrite && mapped;
    assign accRd = psel && penable && !pwrite;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrlQ <= CTRL_RST;
            irqMaskQ <= MASK_RST;
        end else if (accWr && hit(paddr, CTRL_OFS)) begin
            ctrlQ <= pwdata[2:0];
        end else if (accWr && hit(paddr, IRQ_MASK_OFS)) begin
            irqMaskQ <= pwdata[IRQ_W-1:0];
        end
    end

    // Read clears only the bits captured at setup, so a late event is never lost
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irqStatQ <= '0;
        end else if (accRd && hit(paddr, IRQ_STAT_OFS)) begin
            irqStatQ <= (irqStatQ & ~prdata[IRQ_W-1:0]) | irqEv;
        end else begin
            irqStatQ <= irqStatQ | irqEv;
        end
    end
    assign irq = (irqStatQ & irqMaskQ) != '0;

    always_comb begin
        rdData = 32'h0;
        if (hit(paddr, CTRL_OFS)) begin
            rdData[2:0] = ctrlQ;
        end else if (hit(paddr, STATUS_OFS)) begin
            rdData[14:0] = {hicBusy, stateQ, warnS, uvloS, tsdQ, hsBlank, railOnQ};
        end else if (hit(paddr, IRQ_STAT_OFS)) begin
            rdData[IRQ_W-1:0] = irqStatQ;
        end else if (hit(paddr, IRQ_MASK_OFS)) begin
            rdData[IRQ_W-1:0] = irqMaskQ;
        end
    end

    // Read data captured in the setup phase
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdData;
        end
    end

    sequence seqSsDisDone;
        stateQ == S_SSDIS && ivlDone && (pending & selHot) != 3'h0 && !fault;
    endsequence
    sequence seqRampDone;
        stateQ == S_RAMP && ssEndS && (railOnQ & selHot) != 3'h0 && !fault;
    endsequence

    AST_EN_LOW_OFF: assert property (@(posedge mclk) disable iff (!arst_n)
        (enS != 3'h7) |=> ((railOnQ & ~$past(enS)) == 3'h0))
        else $error("rail on while its enable input is low");
    AST_ORDER: assert property (@(posedge mclk) disable iff (!arst_n)
        stateQ == S_IDLE && pending[0] && pending[2] && !fault |=> selQ == 2'h0)
        else $error("default start order not kept");
    AST_FAULT_DISCH: assert property (@(posedge mclk) disable iff (!arst_n)
        fault |=> enDischarge && railOnQ == 3'h0)
        else $error("enable inputs not discharged during a fault");
    AST_SS_PRE: assert property (@(posedge mclk) disable iff (!arst_n)
        seqSsDisDone |=> stateQ == S_PRE && ssPrecharge && !ssCharge)
        else $error("soft-start did not precharge after discharge");
    AST_SS_CHARGE: assert property (@(posedge mclk) disable iff (!arst_n)
        stateQ == S_PRE && ssPreS && (railOnQ & selHot) != 3'h0 && !fault |=> ssCharge)
        else $error("soft-start charge did not follow precharge");
    AST_GAP: assert property (@(posedge mclk) disable iff (!arst_n)
        seqRampDone |=> stateQ == S_GAP && ivlQ == GAP_TICKS)
        else $error("spacing interval not started after ramp");
    AST_TSD: assert property (@(posedge mclk) disable iff (!arst_n)
        tripS |=> tsdQ ##1 (stateQ == S_LOCK && railOnQ == 3'h0))
        else $error("thermal trip did not shut rails down");
    AST_UNDERVOLTAGE_LOCKOUT_REL: assert property (@(posedge mclk) disable iff (!arst_n)
        stateQ == S_LOCK && !fault |=> stateQ == S_DISCH && ivlQ == PWRUP_TICKS)
        else $error("lockout release did not restart the sequence");
    AST_TICK: assert property (@(posedge mclk) disable iff (!arst_n)
        tick && TICK_CYCLES > 1 |=> !tick && tickCntQ == 32'h0)
        else $error("timebase tick malformed");
endmodule

/* File: tb/trs_board.sv */
// Board and analogue model: enable pin wiring, soft-start node, switching clocks.
// Assumes the sequencer drives the discharge and soft-start controls as levels.
`timescale 1ns/10ps
module trs_board #(
    parameter int PRE_CYC = 6,
    parameter int RAMP_CYC = 40,
    parameter int SW_HALF = 8,
    parameter int CAP_CYC = 0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // Enable wiring
    input wire logic [2:0] enTie,
    input wire logic enDischarge,
    output logic [2:0] enPinAbove,
    // Soft-start node
    input wire logic ssDischarge,
    input wire logic ssPrecharge,
    input wire logic ssCharge,
    output logic ssPrechargeOk,
    output logic ssRampEnd,
    // Switching clocks
    output logic [2:0] swCycle
);
    int ssLvl;
    int enRamp;
    int swCnt;
    // Node charge state
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ssLvl <= 0;
        end else if (ssDischarge) begin
            ssLvl <= 0;
        end else if ((ssPrecharge && ssLvl < PRE_CYC) ||
                     (ssCharge && ssLvl < PRE_CYC + RAMP_CYC)) begin
            ssLvl <= ssLvl + 1;
        end
    end
    assign ssPrechargeOk = ssLvl >= PRE_CYC;
    assign ssRampEnd = ssLvl >= PRE_CYC + RAMP_CYC;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            enRamp <= 0;
        end else if (enDischarge) begin
            enRamp <= 0;
        end else if (enRamp < 100000) begin
            enRamp <= enRamp + 1;
        end
    end
    // delays step by rail; step must exceed soft-start plus gap to reorder
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            enPinAbove[i] = enTie[i] && (enRamp >= CAP_CYC * (i + 1));
        end
    end
    // Free-running switching clocks, same phase on every rail
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            swCnt <= 0;
        end else begin
            swCnt <= (swCnt + 1) % (2 * SW_HALF);
        end
    end
    assign swCycle = (swCnt < SW_HALF) ? 3'h7 : 3'h0;
endmodule

/* File: tb/triple_rail_sequencer_tb.sv */
// Self-checking bench for the sequencer top with a board model on its pins.
// Assumes a short timebase tick so every interval completes within the run.
`timescale 1ns/10ps
`define CHK(a, b) check_eq(64'(a), 64'(b))
`define WAIT_UNTIL(c, n) for (int w = 0; w < (n) && !(c); w++) @(posedge mclk)
module triple_rail_sequencer_tb import trs_pkg::*;;
    localparam int TK = 4;
    localparam int MINGAP = 40 + int'(GAP_TICKS) * TK - TK;
    logic mclk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, er, swPrev = 0;
    logic supplyLow = 0, tempTrip = 0, tempCool = 0, tempWarn = 0;
    logic pready, pslverr, enDischarge, ssPrechargeOk, ssRampEnd, ssDischarge, ssPrecharge;
    logic ssCharge, irq;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, r;
    logic [2:0] enPinAbove, enTie = 3'h1, swCycle, overCurrent = 3'h0, underVolt = 3'h0;
    logic [2:0] railEnable, hsBlank;
    int fails = 0, num_checks = 0, cyc = 0, t0, n;

    always #2.5 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    always @(posedge mclk) swPrev <= swCycle[0];

    trs_top #(.TICK_CYCLES(TK)) uut (.mclk(mclk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .enPinAbove(enPinAbove), .enDischarge(enDischarge),
        .ssPrechargeOk(ssPrechargeOk), .ssRampEnd(ssRampEnd), .ssDischarge(ssDischarge),
        .ssPrecharge(ssPrecharge), .ssCharge(ssCharge), .swCycle(swCycle),
        .overCurrent(overCurrent), .underVolt(underVolt), .railEnable(railEnable),
        .hsBlank(hsBlank), .supplyLow(supplyLow), .tempTrip(tempTrip), .tempCool(tempCool),
        .tempWarn(tempWarn), .irq(irq));
    trs_board board (.mclk(mclk), .arst_n(arst_n), .enTie(enTie), .enDischarge(enDischarge),
        .enPinAbove(enPinAbove), .ssDischarge(ssDischarge), .ssPrecharge(ssPrecharge),
        .ssCharge(ssCharge), .ssPrechargeOk(ssPrechargeOk), .ssRampEnd(ssRampEnd),
        .swCycle(swCycle));

    task report_and_stop();
        if (fails == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task check_eq(input logic [63:0] a, input logic [63:0] e);
        num_checks++;
        if (a !== e) begin
            fails++;
            $display("unexpected at %0t: got %0h expected %0h", $time, a, e);
        end
    endtask

    // Request held until pready is seen high at a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    function automatic int exp_len(int k);
        return (k >= 4) ? 16 : (1 << k);
    endfunction

    // Counts raw switching cycles covered by one suppression window on rail 0
    task measure_blank();
        n = 0;
        `WAIT_UNTIL(hsBlank[0] === 1'b1, 400);
        for (int g = 0; g < 2000 && hsBlank[0] === 1'b1; g++) begin
            @(posedge mclk);
            if (swCycle[0] && !swPrev) n++;
        end
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        fails++;
        report_and_stop();
    end

    initial begin
        void'($urandom(68));
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        `CHK(enDischarge, 1'b1);
        `CHK(railEnable, 3'h0);
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        `CHK({er, rd}, 33'h100000000);
        r = $urandom;
        apb(1'b1, IRQ_MASK_OFS, r);
        apb(1'b0, IRQ_MASK_OFS, 32'h0);
        `CHK(rd, r & 32'h3F);
        apb(1'b1, IRQ_MASK_OFS, 32'h0);
        repeat (1500) @(posedge mclk);
        `CHK({enDischarge, railEnable}, 4'h8);
        `WAIT_UNTIL(railEnable[0] === 1'b1, 3000);
        t0 = cyc;
        repeat (20) @(posedge mclk);
        `CHK(railEnable, 3'h1);
        enTie <= 3'h7;
        `WAIT_UNTIL(railEnable === 3'h3, 3000);
        `CHK(railEnable, 3'h3);
        `CHK(cyc - t0 >= MINGAP, 1'b1);
        t0 = cyc;
        `WAIT_UNTIL(railEnable === 3'h7, 3000);
        `CHK(railEnable, 3'h7);
        `CHK(cyc - t0 >= MINGAP, 1'b1);
        overCurrent <= 3'h1;
        for (int k = 0; k < 6; k++) begin
            measure_blank();
            `CHK(n, exp_len(k));
        end
        overCurrent <= 3'h0;
        repeat (40 + $urandom_range(0, 15)) @(posedge mclk);
        overCurrent <= 3'h1;
        measure_blank();
        `CHK(n, 1);
        measure_blank();
        `CHK(n, 2);
        underVolt <= 3'h1;
        `WAIT_UNTIL(railEnable[0] === 1'b0, 200);
        `CHK(railEnable, 3'h6);
        `CHK(irq, 1'b0);
        apb(1'b1, IRQ_MASK_OFS, 32'h8);
        `CHK(irq, 1'b1);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        `CHK(rd, 32'h8);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        `CHK({irq, rd}, 33'h0);
        overCurrent <= 3'h0;
        underVolt <= 3'h0;
        repeat (2500) @(posedge mclk);
        `CHK(railEnable, 3'h6);
        `WAIT_UNTIL(railEnable === 3'h7, 1500);
        `CHK(railEnable, 3'h7);
        tempWarn <= 1'b1;
        repeat (8) @(posedge mclk);
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHK(rd & 32'h107, 32'h107);
        tempWarn <= 1'b0;
        tempTrip <= 1'b1;
        `WAIT_UNTIL(railEnable === 3'h0, 10);
        `CHK({enDischarge, railEnable}, 4'h8);
        tempTrip <= 1'b0;
        repeat (500) @(posedge mclk);
        `CHK({enDischarge, railEnable}, 4'h8);
        tempCool <= 1'b1;
        repeat (1000) @(posedge mclk);
        `CHK({enDischarge, railEnable}, 4'h8);
        `WAIT_UNTIL(railEnable === 3'h7, 6000);
        `CHK(railEnable, 3'h7);
        supplyLow <= 1'b1;
        `WAIT_UNTIL(railEnable === 3'h0, 10);
        `CHK({enDischarge, railEnable}, 4'h8);
        supplyLow <= 1'b0;
        `WAIT_UNTIL(railEnable === 3'h7, 6000);
        `CHK(railEnable, 3'h7);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        `CHK({irq, rd}, 33'h7);
        // Inhibit rail 2, then drop rail 0's enable while rail 2 restarts
        apb(1'b1, CTRL_OFS, 32'h4);
        repeat (4) @(posedge mclk);
        `CHK(railEnable, 3'h3);
        enTie <= 3'h6;
        apb(1'b1, CTRL_OFS, 32'h0);
        repeat (8) @(posedge mclk);
        `CHK(railEnable, 3'h2);
        enTie <= 3'h7;
        `WAIT_UNTIL(railEnable === 3'h7, 3000);
        `CHK(railEnable, 3'h7);
        report_and_stop();
    end
endmodule
